/* File: tec_defines.svh */
// Constants for the dual 8-bit timer/event counter: addresses, control fields, codes.
// Assumes inclusion by the package and the design modules by bare name.
`ifndef TEC_DEFINES_SVH
`define TEC_DEFINES_SVH

// ------------------------------------------------------------------
// Data memory addresses
// ------------------------------------------------------------------
`define TEC_ADDR_T0_COUNT 8'h0d
`define TEC_ADDR_T0_CTRL 8'h0e
`define TEC_ADDR_T1_COUNT 8'h10
`define TEC_ADDR_T1_CTRL 8'h11

// ------------------------------------------------------------------
// Control register fields and values
// ------------------------------------------------------------------
`define TEC_CTRL_RESET 8'h08
`define TEC_CTRL_UNUSED_ZERO 3'h0
`define TEC_MODE_EVENT 2'h1
`define TEC_MODE_TIMER 2'h2
`define TEC_MODE_PULSE 2'h3

// ------------------------------------------------------------------
// Counting constants
// ------------------------------------------------------------------
`define TEC_COUNT_MAX 8'hff
`define TEC_COUNT_RESET 8'h00
`define TEC_COUNT_ONE 8'h01
`define TEC_DIV4_LAST 2'h3
`define TEC_DIV4_STEP 2'h1
`define TEC_DATA_ZERO 8'h00

// ------------------------------------------------------------------
// Build option codes
// ------------------------------------------------------------------
`define TEC_T1_SRC_T0_OVF 2'h0
`define TEC_T1_SRC_SYSCLK 2'h1
`define TEC_T1_SRC_TBASE 2'h2
`define TEC_NUM_CH 2

`endif

/* File: tec_pkg.sv */
// Types shared by the timer/event counter modules.
// Assumes tec_defines.svh is on the include path.
`include "tec_defines.svh"

package tec_pkg;

  // ------------------------------------------------------------------
  // Control register layout, bit 7 down to bit 0
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] mode_select;
    logic clock_source_select;
    logic count_enable;
    logic active_edge_select;
    logic [2:0] unused;
  } tec_ctrl_t;

  // ------------------------------------------------------------------
  // Pulse measurement state
  // ------------------------------------------------------------------
  typedef enum logic {
    TEC_PW_IDLE = 1'b0,
    TEC_PW_RUN = 1'b1
  } tec_pw_state_t;

endpackage

/* File: tec_channel.sv */
// One 8-bit count-up timer/event counter with preload and control register.
// Assumes the external input is synchronous to clk_i and the internal tick is a one-cycle pulse.
`timescale 1ns/1ps
`include "tec_defines.svh"

module tec_channel import tec_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic int_tick_i,
  input wire logic ext_i,
  input wire logic rd_i,
  input wire logic preload_we_i,
  input wire logic ctrl_we_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] count_o,
  output tec_ctrl_t ctrl_o,
  output logic ovf_o
);

  logic ext_q, next_ext_q;
  logic [7:0] count, next_count;
  logic [7:0] preload, next_preload;
  tec_ctrl_t ctrl, next_ctrl;
  tec_pw_state_t state, next_state;
  logic ovf, next_ovf;
  logic rise, fall, act_edge, back_edge, tick, inc;

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    rise = ext_i & ~ext_q;
    fall = ~ext_i & ext_q;
    act_edge = ctrl.active_edge_select ? fall : rise;
    back_edge = ctrl.active_edge_select ? rise : fall;
    next_ext_q = ext_i;
    next_count = count;
    next_preload = preload;
    next_ctrl = ctrl;
    next_state = state;
    next_ovf = 1'b0;
    tick = 1'b0;
    unique case (ctrl.mode_select)
      `TEC_MODE_EVENT: tick = act_edge;
      `TEC_MODE_TIMER: tick = int_tick_i;
      `TEC_MODE_PULSE: tick = (state == TEC_PW_RUN) & int_tick_i;
      default: tick = 1'b0;
    endcase
    // Measurement starts on the active edge and ends on the return edge, or when count enable is cleared or pulse mode is left.
    if (ctrl.mode_select == `TEC_MODE_PULSE && ctrl.count_enable) begin
      unique case (state)
        TEC_PW_IDLE: if (act_edge) next_state = TEC_PW_RUN;
        TEC_PW_RUN: if (back_edge) begin
          next_state = TEC_PW_IDLE;
          next_ctrl.count_enable = 1'b0;
        end
      endcase
    end else begin
      next_state = TEC_PW_IDLE;
    end
    // The clock is held off during a count read so the value cannot tear.
    inc = ctrl.count_enable & tick & ~rd_i;
    if (inc) begin
      if (count == `TEC_COUNT_MAX) begin
        next_count = preload;
        next_ovf = 1'b1;
      end else begin
        next_count = count + `TEC_COUNT_ONE;
      end
    end
    if (preload_we_i) begin
      next_preload = wdata_i;
      if (!ctrl.count_enable) next_count = wdata_i;
    end
    if (ctrl_we_i) begin
      next_ctrl = wdata_i;
      next_ctrl.unused = `TEC_CTRL_UNUSED_ZERO;
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_q <= 1'b0;
      count <= `TEC_COUNT_RESET;
      preload <= `TEC_COUNT_RESET;
      ctrl <= `TEC_CTRL_RESET;
      state <= TEC_PW_IDLE;
      ovf <= 1'b0;
    end else begin
      ext_q <= next_ext_q;
      count <= next_count;
      preload <= next_preload;
      ctrl <= next_ctrl;
      state <= next_state;
      ovf <= next_ovf;
    end
  end

  assign count_o = count;
  assign ctrl_o = ctrl;
  assign ovf_o = ovf;

endmodule // tec_channel

/* File: tec_top.sv */
// Contract
// - Counter 0 counts sysclk or sysclk/4 by option, RTC time-out, or its input.
// - Counter 1 counts counter 0 overflow, sysclk, time base, sysclk/4, or input.
// - Count/preload and control sit at 0DH, 0EH for counter 0, 10H, 11H for 1.
// - Writing the count address loads preload; reading returns the live count.
// - Event mode counts input edges; timer mode counts the internal source.
// - Pulse mode counts the internal source while the input holds its level.
// - Overflow past FFH reloads from preload and sets the counter's interrupt flag.
// - Pulse mode starts on the active edge, stops on return, clears enable.
// - Result stays after a measurement; next needs enable set again; edge driven.
// - Overflow in pulse mode also reloads and raises the interrupt request.
// - Control bit 4 enables counting; hardware clears it only in pulse mode.
// - Control bit 3 picks the edge: 0 rising, 1 falling.
// - Counter 0 bit 5: 0 RTC time-out, 1 optioned system clock form.
// - Counter 1 bit 5: 0 optioned source, 1 system clock divided by four.
// - Control bits 7..6 give mode: 01 event, 10 timer, 11 pulse, 00 unused.
// - Control bits 2..0 always read as zero.
// - Overflow wakes the device; one optioned counter drives the divider output.
// - Port A bit 3 data low enables the divider output, high disables it.
// - A cleared interrupt enable blocks that counter's interrupt in every mode.
// - Preload write also loads the count when stopped, only preload when running.
// - Count clock is blocked during a count read.
//
// Top of the dual timer/event counter, reached over the CPU data memory port.
// Assumes the CPU strobes rd_i or wr_i for one cycle per access and all inputs are
// synchronous to clk_i; tick inputs are one-cycle pulses.
`timescale 1ns/1ps
`include "tec_defines.svh"

module tec_top import tec_pkg::*; #(
  parameter bit T0_SYSCLK_DIV4 = 1'b1,
  parameter logic [1:0] T1_OPT_SRC = `TEC_T1_SRC_T0_OVF,
  parameter bit DIVIDER_FROM_COUNTER1 = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic counter0_input_i,
  input wire logic counter1_input_i,
  input wire logic rtc_timeout_i,
  input wire logic time_base_i,
  input wire logic counter0_irq_enable_i,
  input wire logic counter1_irq_enable_i,
  input wire logic global_irq_enable_i,
  input wire logic counter0_overflow_clear_i,
  input wire logic counter1_overflow_clear_i,
  input wire logic port_a_bit3_data_i,
  output logic counter0_overflow_flag_o,
  output logic counter1_overflow_flag_o,
  output logic counter0_irq_o,
  output logic counter1_irq_o,
  output logic wake_o,
  output logic counter0_overflow_o,
  output logic divider_output_o
);

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
    addr_hit = (a == target);
  endfunction

  localparam logic [7:0] COUNT_ADDR [`TEC_NUM_CH] = '{`TEC_ADDR_T0_COUNT, `TEC_ADDR_T1_COUNT};
  localparam logic [7:0] CTRL_ADDR [`TEC_NUM_CH] = '{`TEC_ADDR_T0_CTRL, `TEC_ADDR_T1_CTRL};

  logic [1:0] div4, next_div4;
  logic div4_tick;
  logic [`TEC_NUM_CH-1:0] int_tick, ext_in, ovf, flag_clr;
  logic [7:0] count [`TEC_NUM_CH];
  tec_ctrl_t ctrl [`TEC_NUM_CH];
  logic [7:0] next_rdata;
  logic [1:0] flag, next_flag;
  logic [1:0] irq, next_irq;
  logic wake, next_wake;
  logic ovf0_q, next_ovf0_q;
  logic divider_output, next_pfd;
  logic pfd_pin, next_pfd_pin;
  logic pfd_src_ovf, pfd_src_on;
  logic t0_sys_tick, t1_opt_tick;

  // ------------------------------------------------------------------
  // Clock sources
  // ------------------------------------------------------------------
  always_comb begin
    next_div4 = div4 + `TEC_DIV4_STEP;
    div4_tick = (div4 == `TEC_DIV4_LAST);
    t0_sys_tick = T0_SYSCLK_DIV4 ? div4_tick : 1'b1;
    int_tick[0] = ctrl[0].clock_source_select ? t0_sys_tick : rtc_timeout_i;
    unique case (T1_OPT_SRC)
      `TEC_T1_SRC_T0_OVF: t1_opt_tick = ovf[0];
      `TEC_T1_SRC_SYSCLK: t1_opt_tick = 1'b1;
      `TEC_T1_SRC_TBASE: t1_opt_tick = time_base_i;
      default: t1_opt_tick = 1'b0;
    endcase
    int_tick[1] = ctrl[1].clock_source_select ? div4_tick : t1_opt_tick;
    ext_in[0] = counter0_input_i;
    ext_in[1] = counter1_input_i;
    flag_clr[0] = counter0_overflow_clear_i;
    flag_clr[1] = counter1_overflow_clear_i;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div4 <= 2'h0;
    end else begin
      div4 <= next_div4;
    end
  end

  // ------------------------------------------------------------------
  // Counter channels
  // ------------------------------------------------------------------
  for (genvar i = 0; i < `TEC_NUM_CH; i++) begin : g_ch
    tec_channel u_ch (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .int_tick_i(int_tick[i]),
      .ext_i(ext_in[i]),
      .rd_i(rd_i & addr_hit(addr_i, COUNT_ADDR[i])),
      .preload_we_i(wr_i & addr_hit(addr_i, COUNT_ADDR[i])),
      .ctrl_we_i(wr_i & addr_hit(addr_i, CTRL_ADDR[i])),
      .wdata_i(wdata_i),
      .count_o(count[i]),
      .ctrl_o(ctrl[i]),
      .ovf_o(ovf[i])
    );
  end

  // ------------------------------------------------------------------
  // Read data, flags, interrupts, wake-up and divider output
  // ------------------------------------------------------------------
  always_comb begin
    next_rdata = rdata_o;
    if (rd_i) begin
      next_rdata = `TEC_DATA_ZERO;
      for (int i = 0; i < `TEC_NUM_CH; i++) begin
        if (addr_hit(addr_i, COUNT_ADDR[i])) next_rdata = count[i];
        if (addr_hit(addr_i, CTRL_ADDR[i])) next_rdata = ctrl[i];
      end
    end
    // A new overflow wins over a clear in the same cycle.
    for (int i = 0; i < `TEC_NUM_CH; i++) begin
      next_flag[i] = ovf[i] | (flag[i] & ~flag_clr[i]);
    end
    next_irq[0] = next_flag[0] & counter0_irq_enable_i & global_irq_enable_i;
    next_irq[1] = next_flag[1] & counter1_irq_enable_i & global_irq_enable_i;
    next_wake = |ovf;
    next_ovf0_q = ovf[0];
    pfd_src_ovf = DIVIDER_FROM_COUNTER1 ? ovf[1] : ovf[0];
    pfd_src_on = DIVIDER_FROM_COUNTER1 ? ctrl[1].count_enable : ctrl[0].count_enable;
    if (!pfd_src_on) begin
      next_pfd = 1'b0;
    end else if (pfd_src_ovf) begin
      next_pfd = ~divider_output;
    end else begin
      next_pfd = divider_output;
    end
    next_pfd_pin = next_pfd & ~port_a_bit3_data_i;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= `TEC_DATA_ZERO;
      flag <= 2'h0;
      irq <= 2'h0;
      wake <= 1'b0;
      ovf0_q <= 1'b0;
      divider_output <= 1'b0;
      pfd_pin <= 1'b0;
    end else begin
      rdata_o <= next_rdata;
      flag <= next_flag;
      irq <= next_irq;
      wake <= next_wake;
      ovf0_q <= next_ovf0_q;
      divider_output <= next_pfd;
      pfd_pin <= next_pfd_pin;
    end
  end

  assign counter0_overflow_flag_o = flag[0];
  assign counter1_overflow_flag_o = flag[1];
  assign counter0_irq_o = irq[0];
  assign counter1_irq_o = irq[1];
  assign wake_o = wake;
  assign counter0_overflow_o = ovf0_q;
  assign divider_output_o = pfd_pin;

endmodule // tec_top

/* File: tec_sig_src.sv */
// Far-side signal source: drives one counter input pin with pulses of a set length.
// Assumes go_i is a one-cycle request made on the rising edge of clk_i.
`timescale 1ns/1ps

module tec_sig_src (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [7:0] len_i,
  output logic pin_o
);
  logic [7:0] left;
  // The pin idles low, as a pulled-down line would between pulses.
  initial begin
    left = 8'h00;
    pin_o = 1'b0;
  end
  always @(posedge clk_i) begin
    if (go_i) begin
      left <= len_i;
      pin_o <= 1'b1;
    end else if (left > 8'h01) begin
      left <= left - 8'h01;
    end else begin
      left <= 8'h00;
      pin_o <= 1'b0;
    end
  end
endmodule // tec_sig_src

/* File: tec_top_properties.sv */
// Concurrent checks on the ports of the dual timer/event counter top.
// Assumes one clock domain and the asynchronous active-high reset rst_i.
`timescale 1ns/1ps

module tec_top_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic counter0_irq_enable_i,
  input wire logic counter0_overflow_clear_i,
  input wire logic port_a_bit3_data_i,
  input wire logic counter0_overflow_flag_o,
  input wire logic counter0_irq_o,
  input wire logic wake_o,
  input wire logic counter0_overflow_o,
  input wire logic divider_output_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_unmapped;
    rd_i && !(addr_i inside {8'h0d, 8'h0e, 8'h10, 8'h11}) |=> rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ctrl_low;
    rd_i && (addr_i == 8'h0e || addr_i == 8'h11) |=> rdata_o[2:0] == 3'h0;
  endproperty
  a_ctrl_low: assert property (p_ctrl_low) else $error("control low bits set");
  property p_rd_hold;
    !rd_i |=> $stable(rdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_flag_set;
    counter0_overflow_o |-> counter0_overflow_flag_o && wake_o;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("overflow without flag");
  property p_flag_hold;
    counter0_overflow_flag_o && !counter0_overflow_clear_i |=> counter0_overflow_flag_o;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");
  property p_irq_mask;
    !$past(counter0_irq_enable_i) |-> !counter0_irq_o;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt");
  property p_strobe;
    counter0_overflow_o |=> !counter0_overflow_o;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe too long");
  property p_div_off;
    port_a_bit3_data_i ##1 port_a_bit3_data_i |-> !divider_output_o;
  endproperty
  a_div_off: assert property (p_div_off) else $error("divider not off");
endmodule // tec_top_properties

bind tec_top tec_top_properties u_chk (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .counter0_irq_enable_i(counter0_irq_enable_i),
  .counter0_overflow_clear_i(counter0_overflow_clear_i),
  .port_a_bit3_data_i(port_a_bit3_data_i), .counter0_overflow_flag_o(counter0_overflow_flag_o),
  .counter0_irq_o(counter0_irq_o), .wake_o(wake_o), .counter0_overflow_o(counter0_overflow_o),
  .divider_output_o(divider_output_o));

/* File: dual_eight_bit_timer_event_counter_tb.sv */
// Self-checking bench for the dual timer/event counter top.
// Assumes the default build options: counter 0 on clock/4, counter 1 on counter 0 overflow.
`timescale 1ns/1ps

module dual_eight_bit_timer_event_counter_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd = 1'b0, ie0 = 1'b0, ie1 = 1'b0, gie = 1'b0;
  logic clr0 = 1'b0, clr1 = 1'b0, pa3 = 1'b0, go0 = 1'b0, go1 = 1'b0, rtc = 1'b0, in0, in1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, len = 8'h02, rdata, v, rdata_hold;
  logic f0, f1, q0, q1, wake, ovf0, div;
  int err_count = 0, check_count = 0;

  always #25 clk_i = ~clk_i;

  tec_sig_src u_src0 (.clk_i(clk_i), .go_i(go0), .len_i(len), .pin_o(in0));
  tec_sig_src u_src1 (.clk_i(clk_i), .go_i(go1), .len_i(len), .pin_o(in1));
  tec_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wr_i(wr), .rd_i(rd),
    .wdata_i(wdata), .rdata_o(rdata), .counter0_input_i(in0), .counter1_input_i(in1),
    .rtc_timeout_i(rtc), .time_base_i(1'b0), .counter0_irq_enable_i(ie0),
    .counter1_irq_enable_i(ie1), .global_irq_enable_i(gie), .counter0_overflow_clear_i(clr0),
    .counter1_overflow_clear_i(clr1), .port_a_bit3_data_i(pa3), .counter0_overflow_flag_o(f0),
    .counter1_overflow_flag_o(f1), .counter0_irq_o(q0), .counter1_irq_o(q1), .wake_o(wake),
    .counter0_overflow_o(ovf0), .divider_output_o(div));

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got);
    chk8({7'h00, got}, 8'h01);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk_i) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i) begin addr <= a; rd <= 1'b1; end
    @(posedge clk_i) rd <= 1'b0;
    #1 d = rdata;
  endtask
  function automatic logic sel(input int k);
    return k == 0 ? ovf0 : k == 1 ? f1 : q0;
  endfunction
  task automatic wait_for(input int k, input int lim);
    int n;
    for (n = 0; n < lim && sel(k) !== 1'b1; n++) @(posedge clk_i) #1;
    if (sel(k) !== 1'b1) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, 1'b0, 1'b1);
      stop_test();
    end
  endtask
  task automatic pulse(input logic which, input logic [7:0] n);
    @(posedge clk_i) begin go0 <= !which; go1 <= which; len <= n; end
    @(posedge clk_i) begin go0 <= 1'b0; go1 <= 1'b0; end
    repeat (n + 8'h06) @(posedge clk_i);
  endtask

  task automatic scen_regs();
    rd_reg(8'h0e, v); chk8(v, 8'h00);
    rd_reg(8'h11, v); chk8(v, 8'h08);
    rd_reg(8'h12, v); chk8(v, 8'h00);
    wr_reg(8'h0e, 8'h47); rd_reg(8'h0e, v); chk8(v, 8'h40);
    wr_reg(8'h0e, 8'h00); wr_reg(8'h0d, 8'h80); wr_reg(8'h0e, 8'h30);
    repeat (20) @(posedge clk_i);
    rd_reg(8'h0d, v); chk8(v, 8'h80);
  endtask
  task automatic scen_timer();
    wr_reg(8'h0e, 8'h00); wr_reg(8'h0d, 8'h00); wr_reg(8'h0e, 8'hb0); wr_reg(8'h0d, 8'hf0);
    wr_reg(8'h0e, 8'ha0); rd_reg(8'h0d, v); chkb(v < 8'hf0);
    wr_reg(8'h0d, 8'hfc); wr_reg(8'h10, 8'hff); wr_reg(8'h11, 8'h90); wr_reg(8'h0e, 8'hb0);
    wait_for(0, 60); chkb(f0 & wake);
    wait_for(1, 10); chkb(!q1);
    wait_for(2, 5); chkb(div);
    wr_reg(8'h0e, 8'h80); wr_reg(8'h11, 8'h80);
    @(posedge clk_i) begin clr0 <= 1'b1; clr1 <= 1'b1; pa3 <= 1'b1; end
    @(posedge clk_i) begin clr0 <= 1'b0; clr1 <= 1'b0; end
    @(posedge clk_i) #1 chkb(!f0 & !f1 & !div);
  endtask
  task automatic scen_event();
    wr_reg(8'h10, 8'hfd); wr_reg(8'h11, 8'h50);
    pulse(1'b1, 8'h02); pulse(1'b1, 8'h02); chkb(!f1);
    @(posedge clk_i) ie1 <= 1'b1;
    pulse(1'b1, 8'h02); wait_for(1, 10); chkb(q1);
    // A falling-edge counter must ignore the rise and count only the fall.
    wr_reg(8'h11, 8'h48); wr_reg(8'h10, 8'h00); wr_reg(8'h11, 8'h58);
    @(posedge clk_i) begin go1 <= 1'b1; len <= 8'h08; end
    @(posedge clk_i) go1 <= 1'b0;
    rd_reg(8'h10, v); chk8(v, 8'h00);
    repeat (10) @(posedge clk_i);
    rd_reg(8'h10, v); chk8(v, 8'h01);
  endtask
  task automatic scen_pulse();
    wr_reg(8'h0e, 8'h00); wr_reg(8'h0d, 8'h00); wr_reg(8'h0e, 8'hf0);
    pulse(1'b0, 8'h28);
    rd_reg(8'h0e, v); chk8(v, 8'he0);
    rd_reg(8'h0d, v); chkb(v >= 8'h09 && v <= 8'h0b);
    pulse(1'b0, 8'h10);
    rd_reg(8'h0d, rdata_hold); chk8(rdata_hold, v);
  endtask
  task automatic scen_rtc();
    wr_reg(8'h0e, 8'h00); wr_reg(8'h0d, 8'h00); wr_reg(8'h0e, 8'h90);
    repeat (3) begin
      @(posedge clk_i) rtc <= 1'b1;
      @(posedge clk_i) rtc <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
    wr_reg(8'h0e, 8'h80); rd_reg(8'h0d, v); chk8(v, 8'h03);
  endtask
  task automatic scen_reset();
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_reg(8'h0e, v); chk8(v, 8'h08);
    rd_reg(8'h0d, v); chk8(v, 8'h00);
    chkb(!f0 & !f1 & !q0 & !div);
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    ie0 <= 1'b1;
    gie <= 1'b1;
    wr_reg(8'h0e, 8'h10); wr_reg(8'h0e, 8'h00);
    scen_regs();
    scen_timer();
    scen_event();
    scen_pulse();
    scen_rtc();
    scen_reset();
    stop_test();
  end
endmodule // dual_eight_bit_timer_event_counter_tb
